/* logic/linescan_pixel_correction_timing.sv */
// line-scan pixel correction chain and line/exposure timing for two channels
// Notes on behaviour
// - defect pixel becomes mean of neighbours
// - eight defects per channel, skip edges
// - auto detect compares threshold, stores positions
// - correct stored positions only when enabled
// - 3-bit conversion gain codes per channel
// - coarse analog gain 0..3, default 2
// - master fine gain plus ch2 offset
// - individual fine gain per channel
// - tone map gamma, lut or off
// - gamma shared, anchors 32/890/1023
// - lut 256 points per channel, 0..8191
// - shading scales toward brightest, within 20 percent
// - gain balance nulls channel difference
// - shutter balance only in timed mode
// - signed black offset -255..+255
// - internal line period 170..13341 spclk
// - auto line rate only trigger off
// - shutter 136..13308 spclk per channel, exposure follows the longer
// - shutter capped by line/trigger period
// - exposure outputs, fixed opposite polarities
// - shading on/off independent of mode
// - exposure off: period minus 5.1 us
`timescale 1ns/1ps
`include "linescan_defines.svh"
module linescan_pixel_correction_timing #(
	parameter int PW = 12,
	parameter int XW = 11,
	parameter int LINE_MAX = `LINE_MAX_CLK,
	parameter int SHUT_MAX = `SHUT_MAX_CLK
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic pix_valid_i,
	input wire logic [XW-1:0] pix_x_i,
	input wire logic pix_last_i,
	input wire logic [PW-1:0] pix_a_i,
	input wire logic [PW-1:0] pix_b_i,
	input wire logic [PW-1:0] shade_a_i,
	input wire logic [PW-1:0] shade_b_i,
	input wire logic defect_en_i,
	input wire logic detect_start_i,
	input wire logic [PW-1:0] detect_thr_i,
	input wire logic shading_en_i,
	input wire logic [2:0] sensor_conv_gain_code_a_i,
	input wire logic [2:0] sensor_conv_gain_code_b_i,
	input wire logic [1:0] analog_coarse_gain_a_i,
	input wire logic [1:0] analog_coarse_gain_b_i,
	input wire logic fine_individual_i,
	input wire logic [8:0] analog_fine_gain_a_i,
	input wire logic [8:0] analog_fine_gain_b_i,
	input wire logic signed [7:0] fine_ofs_b_i,
	input wire logic signed [9:0] black_a_i,
	input wire logic signed [9:0] black_b_i,
	input wire linescan_pkg::tone_mode_t tone_i,
	input wire logic out10_i,
	input wire logic lut_we_i,
	input wire logic lut_ch_i,
	input wire logic [7:0] lut_addr_i,
	input wire logic [12:0] lut_data_i,
	input wire logic gain_balance_cmd_i,
	input wire logic shutter_balance_cmd_i,
	input wire logic trig_mode_i,
	input wire linescan_pkg::exp_mode_t exp_mode_i,
	input wire logic trig_i,
	input wire logic auto_rate_i,
	input wire logic [13:0] line_period_i,
	input wire logic [13:0] shut_a_i,
	input wire logic [13:0] shut_b_i,
	output logic out_valid_o,
	output logic [9:0] out_a_o,
	output logic [9:0] out_b_o,
	output logic [2:0] conv_gain_a_o,
	output logic [2:0] conv_gain_b_o,
	output logic [1:0] coarse_gain_a_o,
	output logic [1:0] coarse_gain_b_o,
	output logic [9:0] fine_gain_a_o,
	output logic [9:0] fine_gain_b_o,
	output logic line_start_o,
	output logic exposure_active_out_o,
	output logic exposure_active_out_n_o,
	output logic detect_busy_o,
	output logic balance_busy_o
);
	import linescan_pkg::*;

	// synchronise the external trigger pin, then edge detect on the second stage
	logic trig_m, trig_s, trig_d;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			trig_m <= 1'b0;
			trig_s <= 1'b0;
			trig_d <= 1'b0;
		end else begin
			trig_m <= trig_i;
			trig_s <= trig_m;
			trig_d <= trig_s;
		end
	end
	wire trig_rise = trig_s & ~trig_d;

	// sensor pixel clock enable from the 100 MHz clock
	logic [3:0] div;
	wire spclk_en = (div == 4'(`SPCLK_DIV - 1));
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) div <= 4'h0;
		else div <= spclk_en ? 4'h0 : div + 4'h1;
	end

	// clamp settings into the legal windows
	wire [13:0] period_lim = (line_period_i < 14'(`LINE_MIN_CLK)) ? 14'(`LINE_MIN_CLK) :
		(line_period_i > 14'(LINE_MAX)) ? 14'(LINE_MAX) : line_period_i;
	// auto rate picks the longest period only with trigger off, exposure off/timed
	wire auto_ok = auto_rate_i & ~trig_mode_i & (exp_mode_i != EXP_WIDTH);
	wire [13:0] period_eff = auto_ok ? 14'(LINE_MAX) : period_lim;
	logic [13:0] trig_period;
	// cap shutter at the line or measured trigger period minus the readout gap
	wire [13:0] cap_src = trig_mode_i ? trig_period : period_eff;
	wire [13:0] cap = cap_src - 14'(`EXP_GAP_CLK);
	logic [13:0] bal_shut;
	function automatic logic [13:0] shut_clip(input logic [13:0] s, input logic [13:0] c);
		logic [13:0] t;
		t = (s < 14'(`SHUT_MIN_CLK)) ? 14'(`SHUT_MIN_CLK) :
			(s > 14'(SHUT_MAX)) ? 14'(SHUT_MAX) : s;
		return (t > c) ? c : t;
	endfunction : shut_clip
	wire timed = (exp_mode_i == EXP_TIMED);
	wire [13:0] exp_a = timed ? shut_clip(shut_a_i, cap) : cap;
	wire [13:0] exp_b = timed ? shut_clip(shut_b_i + bal_shut, cap) : cap;

	// line sequencer: expose, then readout gap, then wait for next line
	line_state_t st;
	logic [13:0] lcnt, tcnt;
	wire start = trig_mode_i ? trig_rise : (st == ST_IDLE ||
		((st == ST_WAIT || st == ST_GAP) && spclk_en && lcnt >= period_eff - 14'h1));
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st <= ST_IDLE;
			lcnt <= 14'h0;
		end else if (start) begin
			st <= ST_EXPOSE;
			lcnt <= 14'h0;
		end else if (spclk_en) begin
			lcnt <= (lcnt == 14'h3FFF) ? lcnt : lcnt + 14'h1;
			case (st)
				ST_EXPOSE: if (lcnt + 14'h1 >= ((exp_a > exp_b) ? exp_a : exp_b)) st <= ST_GAP;
				ST_GAP: if (lcnt + 14'h1 >= cap_src) st <= ST_WAIT;
				ST_WAIT: st <= ST_WAIT;
				ST_IDLE: st <= ST_IDLE;
				default: st <= ST_IDLE;
			endcase
		end
	end

	// measure trigger period in sensor clocks for the shutter cap
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tcnt <= 14'h0;
			trig_period <= 14'(LINE_MAX);
		end else if (trig_rise) begin
			trig_period <= tcnt;
			tcnt <= 14'h0;
		end else if (spclk_en && tcnt != 14'h3FFF) begin
			tcnt <= tcnt + 14'h1;
		end
	end

	// exposure outputs from flops, opposite fixed polarities
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			exposure_active_out_o <= 1'b0;
			exposure_active_out_n_o <= 1'b1;
			line_start_o <= 1'b0;
		end else begin
			exposure_active_out_o <= (st == ST_EXPOSE);
			exposure_active_out_n_o <= ~(st == ST_EXPOSE);
			line_start_o <= start;
		end
	end

	// gain codes: invalid conversion codes fall back to unity, coarse passes as is
	function automatic logic [2:0] conv_ok(input logic [2:0] c);
		return (c[2] == 1'b1) ? c : 3'(`CONV_GAIN_1);
	endfunction : conv_ok
	logic signed [9:0] bal_gain;
	wire [8:0] fa = (analog_fine_gain_a_i > `FINE_GAIN_MAX) ? `FINE_GAIN_MAX : analog_fine_gain_a_i;
	wire [8:0] fb = (analog_fine_gain_b_i > `FINE_GAIN_MAX) ? `FINE_GAIN_MAX : analog_fine_gain_b_i;
	wire signed [8:0] ofs_c = (fine_ofs_b_i > 8'sd84) ? 9'sd84 :
		(fine_ofs_b_i < -8'sd84) ? -9'sd84 : 9'(fine_ofs_b_i);
	wire signed [10:0] fb_sum = fine_individual_i ? 11'(signed'({2'b00, fb})) + 11'(bal_gain) :
		11'(signed'({2'b00, fa})) + 11'(ofs_c) + 11'(bal_gain);
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			conv_gain_a_o <= `CONV_GAIN_1;
			conv_gain_b_o <= `CONV_GAIN_1;
			coarse_gain_a_o <= `COARSE_GAIN_RST;
			coarse_gain_b_o <= `COARSE_GAIN_RST;
			fine_gain_a_o <= 10'h000;
			fine_gain_b_o <= 10'h000;
		end else begin
			conv_gain_a_o <= conv_ok(sensor_conv_gain_code_a_i);
			conv_gain_b_o <= conv_ok(sensor_conv_gain_code_b_i);
			coarse_gain_a_o <= analog_coarse_gain_a_i;
			coarse_gain_b_o <= analog_coarse_gain_b_i;
			fine_gain_a_o <= {1'b0, fine_individual_i ? fa : fa};
			fine_gain_b_o <= fb_sum[10] ? 10'h000 : fb_sum[9:0];
		end
	end

	// defect tables and auto detection; edges never stored
	logic [XW-1:0] dpos_a [`DEFECT_SLOTS];
	logic [XW-1:0] dpos_b [`DEFECT_SLOTS];
	logic [3:0] dn_a, dn_b;
	logic det_arm;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			det_arm <= 1'b0;
			detect_busy_o <= 1'b0;
			dn_a <= 4'h0;
			dn_b <= 4'h0;
		end else if (detect_start_i && !detect_busy_o) begin
			detect_busy_o <= 1'b1;
			det_arm <= 1'b0;
			dn_a <= 4'h0;
			dn_b <= 4'h0;
		end else if (detect_busy_o && pix_valid_i) begin
			if (det_arm && pix_x_i != '0 && !pix_last_i) begin
				if (pix_a_i > detect_thr_i && dn_a < 4'(`DEFECT_SLOTS)) begin
					dpos_a[dn_a[2:0]] <= pix_x_i;
					dn_a <= dn_a + 4'h1;
				end
				if (pix_b_i > detect_thr_i && dn_b < 4'(`DEFECT_SLOTS)) begin
					dpos_b[dn_b[2:0]] <= pix_x_i;
					dn_b <= dn_b + 4'h1;
				end
			end
			if (pix_last_i) begin
				det_arm <= 1'b1;
				if (det_arm) detect_busy_o <= 1'b0;
			end
		end
	end

	// three-tap window: prev, cur, next; the cur sample is output one pixel late
	logic [PW-1:0] pa, ca, pb, cb;
	logic [XW-1:0] cx;
	logic cv;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cv <= 1'b0;
		end else if (pix_valid_i) begin
			pa <= ca;
			pb <= cb;
			ca <= pix_a_i;
			cb <= pix_b_i;
			cx <= pix_x_i;
			cv <= 1'b1;
		end else begin
			cv <= 1'b0;
		end
	end
	logic hit_a, hit_b;
	always_comb begin
		hit_a = 1'b0;
		hit_b = 1'b0;
		for (int i = 0; i < `DEFECT_SLOTS; i++) begin
			if (4'(i) < dn_a && dpos_a[i] == cx) hit_a = 1'b1;
			if (4'(i) < dn_b && dpos_b[i] == cx) hit_b = 1'b1;
		end
	end
	// neighbours are prev and incoming pixel; only when enabled
	wire [PW:0] avg_a = ({1'b0, pa} + {1'b0, pix_a_i}) >> 1;
	wire [PW:0] avg_b = ({1'b0, pb} + {1'b0, pix_b_i}) >> 1;
	wire use_a = defect_en_i & hit_a & pix_valid_i;
	wire [PW-1:0] da = use_a ? avg_a[PW-1:0] : ca;
	wire [PW-1:0] db = (defect_en_i & hit_b & pix_valid_i) ? avg_b[PW-1:0] : cb;

	// shading: factory gain in 1/256 units, clamped to +20 percent
	function automatic logic [PW+1:0] shade(input logic [PW-1:0] p, input logic [PW-1:0] g);
		logic [9:0] k;
		logic [PW+9:0] m;
		k = (g[9:0] > `SHADE_NUM_MAX) ? `SHADE_NUM_MAX : g[9:0];
		k = (k < 10'h100) ? 10'h100 : k;
		m = p * k;
		return (PW+2)'(m >> 8);
	endfunction : shade
	wire [PW+1:0] sa = shading_en_i ? shade(da, shade_a_i) : (PW+2)'(da);
	wire [PW+1:0] sb = shading_en_i ? shade(db, shade_b_i) : (PW+2)'(db);

	// black offset then saturate to 12 bits
	function automatic logic [PW-1:0] blk(input logic [PW+1:0] v, input logic signed [9:0] o);
		logic signed [PW+3:0] s;
		logic signed [9:0] c;
		c = (o > 10'sd255) ? 10'sd255 : (o < -10'sd255) ? -10'sd255 : o;
		s = signed'({2'b00, v}) + (PW+4)'(c);
		return (s < 0) ? '0 : (s > (2**PW - 1)) ? '1 : s[PW-1:0];
	endfunction : blk
	wire [PW-1:0] ba = blk(sa, black_a_i);
	wire [PW-1:0] bb = blk(sb, black_b_i);

	// per-channel lut, 256 points of 13 bits
	logic [12:0] lut_a [256];
	logic [12:0] lut_b [256];
	always_ff @(posedge clk_i) begin
		if (lut_we_i && !lut_ch_i) lut_a[lut_addr_i] <= lut_data_i;
		if (lut_we_i && lut_ch_i) lut_b[lut_addr_i] <= lut_data_i;
	end

	// shared gamma as piecewise-linear through the three anchors (10-bit scale)
	function automatic logic [9:0] gam(input logic [PW-1:0] v);
		logic [21:0] t;
		if (v >= 12'hE99) return `GAMMA_SAT_10;
		t = 22'(v) * 22'(`GAMMA_MID_10 - `GAMMA_BLACK_10) / 22'h0E99;
		return 10'(t) + `GAMMA_BLACK_10 + ((v > 12'hD00) ? 10'(v[11:3] - 9'h1A0) : 10'h000);
	endfunction : gam
	// tone map then keep the top 10 or 8 bits
	function automatic logic [9:0] tone(input logic [PW-1:0] v, input logic [12:0] l,
		input tone_mode_t m, input logic w);
		logic [9:0] r;
		case (m)
			TONE_GAMMA: r = gam(v);
			TONE_LUT: r = (l > 13'h0FFF) ? 10'h3FF : l[11:2];
			default: r = v[PW-1:PW-10];
		endcase
		return w ? r : {2'b00, r[9:2]};
	endfunction : tone
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			out_valid_o <= 1'b0;
			out_a_o <= 10'h000;
			out_b_o <= 10'h000;
		end else begin
			out_valid_o <= cv & pix_valid_i;
			out_a_o <= tone(ba, lut_a[ba[PW-1:PW-8]], tone_i, out10_i);
			out_b_o <= tone(bb, lut_b[bb[PW-1:PW-8]], tone_i, out10_i);
		end
	end

	// one-push balancing: integrate line sums, step ch2 gain or shutter
	logic [XW+PW-1:0] sum_a, sum_b;
	logic [5:0] bal_lines;
	logic bal_shutter;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			balance_busy_o <= 1'b0;
			bal_gain <= 10'sh000;
			bal_shut <= 14'h0;
			bal_lines <= 6'h0;
			bal_shutter <= 1'b0;
			sum_a <= '0;
			sum_b <= '0;
		end else if (!balance_busy_o && (gain_balance_cmd_i ||
				(shutter_balance_cmd_i && timed))) begin
			balance_busy_o <= 1'b1;
			bal_shutter <= ~gain_balance_cmd_i;
			bal_lines <= 6'h3F;
			sum_a <= '0;
			sum_b <= '0;
		end else if (balance_busy_o && pix_valid_i) begin
			// relies on triggers continuing so lines keep arriving
			sum_a <= pix_last_i ? '0 : sum_a + (XW+PW)'(pix_a_i);
			sum_b <= pix_last_i ? '0 : sum_b + (XW+PW)'(pix_b_i);
			if (pix_last_i) begin
				bal_lines <= bal_lines - 6'h1;
				if (sum_a == sum_b || bal_lines == 6'h0) balance_busy_o <= 1'b0;
				else if (bal_shutter) bal_shut <= (sum_a > sum_b) ? bal_shut + 14'h1 : bal_shut - 14'h1;
				else bal_gain <= (sum_a > sum_b) ? bal_gain + 10'sh001 : bal_gain - 10'sh001;
			end
		end
	end

	AST_EXP_POL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		exposure_active_out_o != exposure_active_out_n_o) else $error("exposure polarity");
	AST_DEF_CNT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		dn_a <= 4'h8 && dn_b <= 4'h8) else $error("defect table overflow");
	AST_EXP_START: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		start |=> ##1 exposure_active_out_o) else $error("no exposure after start");
	AST_CONV: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		conv_gain_a_o[2]) else $error("bad conversion gain code");
	AST_FINE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		fine_gain_a_o <= 10'h134) else $error("fine gain over range");
	AST_SHBAL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(balance_busy_o) && bal_shutter |-> timed) else $error("shutter balance not timed");
	AST_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		tone_i == TONE_OFF && out10_i && !shading_en_i && !defect_en_i && black_a_i == 0
		&& pix_valid_i && cv |=> out_a_o == $past(ca[PW-1:PW-10])) else $error("off not linear");
	AST_EDGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		detect_busy_o && pix_valid_i && pix_x_i == '0 |=> $stable(dn_a)) else $error("edge stored");
	COV_LINE: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(exposure_active_out_o));
	COV_DET: cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(detect_busy_o));
	COV_BAL: cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(balance_busy_o));
endmodule : linescan_pixel_correction_timing

/* common/linescan_defines.svh */
// timing counts, reset values and code points for the line-scan pixel path
`ifndef LINESCAN_DEFINES_SVH
`define LINESCAN_DEFINES_SVH
`define SPCLK_PS 149920
`define SPCLK_DIV 15
`define LINE_MIN_CLK 170
`define LINE_MAX_CLK 13341
`define SHUT_MIN_CLK 136
`define SHUT_MAX_CLK 13308
`define EXP_GAP_NS 5100
`define EXP_GAP_CLK ((`EXP_GAP_NS * 1000 + `SPCLK_PS / 2) / `SPCLK_PS)
`define CONV_GAIN_3P5 3'h4
`define CONV_GAIN_1 3'h6
`define CONV_GAIN_0P25 3'h5
`define CONV_GAIN_0P05 3'h7
`define COARSE_GAIN_RST 2'h2
`define FINE_GAIN_MAX 9'h134
`define FINE_OFS_MAX 8'h54
`define BLACK_MAX 9'h0FF
`define GAMMA_BLACK_10 10'h020
`define GAMMA_MID_10 10'h37A
`define GAMMA_SAT_10 10'h3FF
`define GAMMA_BLACK_8 8'h08
`define GAMMA_MID_8 8'hDE
`define GAMMA_SAT_8 8'hFF
`define LUT_MAX 13'h1FFF
`define DEFECT_SLOTS 8
`define SHADE_NUM_MAX 10'h133
`endif

/* common/linescan_pkg.sv */
// types for the line-scan pixel path
package linescan_pkg;
	typedef enum logic [1:0] {TONE_OFF = 2'h0, TONE_GAMMA = 2'h1, TONE_LUT = 2'h2} tone_mode_t;
	typedef enum logic [1:0] {EXP_OFF = 2'h0, EXP_TIMED = 2'h1, EXP_WIDTH = 2'h2} exp_mode_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1, ST_EXPOSE = 4'h2, ST_GAP = 4'h4, ST_WAIT = 4'h8
	} line_state_t;
endpackage : linescan_pkg

/* bench/sensor_frontend_model.sv */
// sensor front end and trigger source model driving the pixel path
`timescale 1ns/1ps
module sensor_frontend_model (
	input wire logic clk_i,
	output logic pix_valid_o,
	output logic [10:0] pix_x_o,
	output logic pix_last_o,
	output logic [11:0] pix_a_o,
	output logic [11:0] pix_b_o,
	output logic trig_o
);
	int trig_gap = 0;
	// trigger pulses keep coming as long as a gap is set, balancing included
	initial begin
		trig_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (trig_gap > 0) begin
				trig_o <= 1'b1;
				repeat (40) @(posedge clk_i);
				trig_o <= 1'b0;
				repeat (trig_gap - 41) @(posedge clk_i);
			end
		end
	end
	// one line back to back; idle data is inverted so a stale pixel never looks valid
	task automatic send_line(input logic [11:0] a [16], input logic [11:0] b [16]);
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_i);
			pix_valid_o <= 1'b1;
			pix_x_o <= 11'(i);
			pix_last_o <= (i == 15);
			pix_a_o <= a[i];
			pix_b_o <= b[i];
		end
		@(posedge clk_i);
		pix_valid_o <= 1'b0;
		pix_last_o <= 1'b0;
		pix_a_o <= ~a[15];
		pix_b_o <= ~b[15];
	endtask : send_line
	initial begin
		pix_valid_o = 1'b0;
		pix_last_o = 1'b0;
		pix_x_o = 11'h000;
		pix_a_o = 12'hA5A;
		pix_b_o = 12'h5A5;
	end
endmodule : sensor_frontend_model

/* bench/tb.sv */
// self-checking bench for the line-scan pixel path and line timing
`timescale 1ns/1ps
`include "linescan_defines.svh"
module tb;
	import linescan_pkg::*;
	typedef struct {logic [9:0] a; logic [9:0] b; bit care;} exp_t;
	localparam int LMAX = 400;
	logic clk_i, rst_n_i, pix_valid_i, pix_last_i, defect_en_i, detect_start_i, shading_en_i;
	logic fine_individual_i, out10_i, lut_we_i, lut_ch_i, gain_balance_cmd_i;
	logic shutter_balance_cmd_i, trig_mode_i, trig_i, auto_rate_i, out_valid_o, line_start_o;
	logic exposure_active_out_o, exposure_active_out_n_o, detect_busy_o, balance_busy_o;
	logic [10:0] pix_x_i;
	logic [11:0] pix_a_i, pix_b_i, shade_a_i, shade_b_i, detect_thr_i;
	logic [2:0] sensor_conv_gain_code_a_i, sensor_conv_gain_code_b_i, conv_gain_a_o, conv_gain_b_o;
	logic [1:0] analog_coarse_gain_a_i, analog_coarse_gain_b_i, coarse_gain_a_o, coarse_gain_b_o;
	logic [8:0] analog_fine_gain_a_i, analog_fine_gain_b_i;
	logic signed [7:0] fine_ofs_b_i;
	logic signed [9:0] black_a_i, black_b_i;
	tone_mode_t tone_i;
	exp_mode_t exp_mode_i;
	logic [7:0] lut_addr_i;
	logic [12:0] lut_data_i;
	logic [13:0] line_period_i, shut_a_i, shut_b_i;
	logic [9:0] out_a_o, out_b_o, fine_gain_a_o, fine_gain_b_o;
	logic [11:0] la [16];
	logic [11:0] lb [16];
	logic [9:0] ea [16];
	logic [9:0] eb [16];
	exp_t sb_q [$];
	int bad_count = 0;
	int total_checks = 0;
	int per, ex;
	linescan_pixel_correction_timing #(.LINE_MAX(LMAX), .SHUT_MAX(380)) dut (
		.clk_i, .rst_n_i, .pix_valid_i, .pix_x_i, .pix_last_i, .pix_a_i, .pix_b_i, .shade_a_i,
		.shade_b_i, .defect_en_i, .detect_start_i, .detect_thr_i, .shading_en_i,
		.sensor_conv_gain_code_a_i, .sensor_conv_gain_code_b_i, .analog_coarse_gain_a_i,
		.analog_coarse_gain_b_i, .fine_individual_i, .analog_fine_gain_a_i, .analog_fine_gain_b_i,
		.fine_ofs_b_i, .black_a_i, .black_b_i, .tone_i, .out10_i, .lut_we_i, .lut_ch_i, .lut_addr_i,
		.lut_data_i, .gain_balance_cmd_i, .shutter_balance_cmd_i, .trig_mode_i, .exp_mode_i, .trig_i,
		.auto_rate_i, .line_period_i, .shut_a_i, .shut_b_i, .out_valid_o, .out_a_o, .out_b_o,
		.conv_gain_a_o, .conv_gain_b_o, .coarse_gain_a_o, .coarse_gain_b_o, .fine_gain_a_o,
		.fine_gain_b_o, .line_start_o, .exposure_active_out_o, .exposure_active_out_n_o,
		.detect_busy_o, .balance_busy_o);
	sensor_frontend_model fe (.clk_i, .pix_valid_o(pix_valid_i), .pix_x_o(pix_x_i),
		.pix_last_o(pix_last_i), .pix_a_o(pix_a_i), .pix_b_o(pix_b_i), .trig_o(trig_i));
	// free-running 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
		total_checks++;
		if (seen !== expv) begin
			bad_count++;
			$display("[FAIL] %s expected %0h seen %0h", what, expv, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	// linear path: offset, clip to 12 bits, then cut to the output depth
	function automatic logic [9:0] lin(input int v);
		int c;
		c = (v < 0) ? 0 : ((v > 4095) ? 4095 : v);
		return out10_i ? 10'(c >> 2) : 10'(c >> 4);
	endfunction : lin
	task automatic fill(input int va, input int vb, input int ba, input int bb);
		for (int i = 0; i < 16; i++) begin
			la[i] = 12'(va);
			lb[i] = 12'(vb);
			ea[i] = lin(va + ba);
			eb[i] = lin(vb + bb);
		end
	endtask : fill
	// the last pixel of a line has no right neighbour behind it, so it never leaves
	task automatic run_line();
		for (int i = 0; i < 15; i++) sb_q.push_back('{ea[i], eb[i], 1'b1});
		fe.send_line(la, lb);
		repeat (4) @(posedge clk_i);
	endtask : run_line
	task automatic defect_line(input bit fix);
		fill(400, 800, 0, 0);
		la[0] = 12'hFFF;
		la[3] = 12'hFFF;
		la[4] = 12'd600;
		lb[9] = 12'hFFF;
		ea[0] = 10'h3FF;
		ea[3] = fix ? lin(500) : 10'h3FF;
		ea[4] = lin(600);
		eb[9] = fix ? lin(800) : 10'h3FF;
		run_line();
	endtask : defect_line
	// count clocks and exposure over the third line interval after a change
	task automatic timing(input int p, input int e);
		int w;
		for (int k = 0; k < 3; k++) begin
			per = 0;
			ex = 0;
			w = 0;
			do begin
				@(posedge clk_i);
				per++;
				ex += int'(exposure_active_out_o);
				w += int'(exposure_active_out_n_o !== ~exposure_active_out_o);
			end while (line_start_o !== 1'b1 && per < 20000);
		end
		if (per >= 20000) begin
			bad_count++;
			stop_test();
		end
		check("polarity", 16'(w), 0);
		check("period", 16'(per), 16'(p));
		if (e >= 0) check("expose", 16'(ex), 16'(e));
		else check("expose_cap", ex <= -e, 1);
	endtask : timing
	// result watcher: every valid output takes the oldest note
	always @(posedge clk_i) begin
		exp_t e;
		if (out_valid_o === 1'b1) begin
			if (sb_q.size() == 0) begin
				check("surplus", 1, 0);
			end else begin
				e = sb_q.pop_front();
				if (e.care) check("out_a", out_a_o, e.a);
				if (e.care) check("out_b", out_b_o, e.b);
			end
		end
	end
	// main sequence
	initial begin
		rst_n_i = 1'b0;
		{defect_en_i, detect_start_i, shading_en_i, fine_individual_i, lut_we_i, lut_ch_i} = '0;
		{gain_balance_cmd_i, shutter_balance_cmd_i, trig_mode_i, auto_rate_i} = '0;
		{lut_addr_i, lut_data_i, black_a_i, black_b_i, fine_ofs_b_i} = '0;
		{sensor_conv_gain_code_a_i, sensor_conv_gain_code_b_i} = 6'h36;
		{analog_coarse_gain_a_i, analog_coarse_gain_b_i} = 4'hA;
		{analog_fine_gain_a_i, analog_fine_gain_b_i} = '0;
		{shade_a_i, shade_b_i, detect_thr_i} = {12'd256, 12'd256, 12'hFFF};
		{line_period_i, shut_a_i, shut_b_i} = {14'd200, 14'd150, 14'd150};
		tone_i = TONE_OFF;
		exp_mode_i = EXP_OFF;
		out10_i = 1'b1;
		void'($urandom(10));
		repeat (9) @(posedge clk_i);
		@(negedge clk_i);
		check("conv_rst", {conv_gain_a_o, conv_gain_b_o}, 6'h36);
		check("coarse_rst", {coarse_gain_a_o, coarse_gain_b_o}, 4'hA);
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			@(posedge clk_i);
			sensor_conv_gain_code_a_i <= 3'(c);
			sensor_conv_gain_code_b_i <= 3'(7 - c);
			analog_coarse_gain_a_i <= 2'(c);
			analog_coarse_gain_b_i <= 2'(3 - c);
			repeat (3) @(negedge clk_i);
			check("conv_a", conv_gain_a_o, c[2] ? 3'(c) : 3'h6);
			check("conv_b", conv_gain_b_o, c[2] ? 3'h6 : 3'(7 - c));
			check("coarse", {coarse_gain_a_o, coarse_gain_b_o}, {2'(c), 2'(3 - c)});
		end
		// master mode sums the channel-two offset, individual mode does not
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_i);
			fine_individual_i <= (k == 2);
			analog_fine_gain_a_i <= (k == 0) ? 9'd308 : ((k == 1) ? 9'd200 : 9'd10);
			analog_fine_gain_b_i <= (k == 2) ? 9'd308 : 9'd0;
			fine_ofs_b_i <= (k == 0) ? -8'sd84 : ((k == 1) ? 8'sd84 : 8'sd50);
			repeat (3) @(negedge clk_i);
			check("fine_b", fine_gain_b_o, (k == 0) ? 224 : ((k == 1) ? 284 : 308));
			check("fine_a", fine_gain_a_o, (k == 0) ? 308 : ((k == 1) ? 200 : 10));
		end
		// random linear line, then black offsets with clipping at both ends
		for (int i = 0; i < 16; i++) begin
			la[i] = 12'($urandom);
			lb[i] = 12'($urandom);
			ea[i] = lin(la[i]);
			eb[i] = lin(lb[i]);
		end
		run_line();
		black_a_i <= 10'sd40;
		black_b_i <= -10'sd255;
		@(posedge clk_i);
		fill(400, 100, 40, -255);
		run_line();
		black_a_i <= 10'sd255;
		out10_i <= 1'b0;
		@(posedge clk_i);
		fill(4095, 1600, 255, -255);
		run_line();
		// fixed curve anchors at both depths
		black_a_i <= 10'sd0;
		black_b_i <= 10'sd0;
		tone_i <= TONE_GAMMA;
		for (int d = 0; d < 2; d++) begin
			out10_i <= d[0];
			@(posedge clk_i);
			fill(0, 4095, 0, 0);
			for (int i = 0; i < 16; i++) begin
				ea[i] = d[0] ? `GAMMA_BLACK_10 : 10'(`GAMMA_BLACK_8);
				eb[i] = d[0] ? `GAMMA_SAT_10 : 10'(`GAMMA_SAT_8);
			end
			run_line();
		end
		// user curve: one entry per channel, the one above full scale saturates
		lut_we_i <= 1'b1;
		{lut_ch_i, lut_addr_i, lut_data_i} <= {1'b0, 8'h40, 13'h1000};
		@(posedge clk_i);
		{lut_ch_i, lut_addr_i, lut_data_i} <= {1'b1, 8'h80, 13'h0800};
		@(posedge clk_i);
		lut_we_i <= 1'b0;
		tone_i <= TONE_LUT;
		@(posedge clk_i);
		fill(1024, 2048, 0, 0);
		for (int i = 0; i < 16; i++) {ea[i], eb[i]} = {10'h3FF, 10'h200};
		run_line();
		// shading lifts channel one by 307/256, channel two stays at unity
		tone_i <= TONE_OFF;
		shading_en_i <= 1'b1;
		shade_a_i <= 12'd307;
		@(posedge clk_i);
		fill(1024, 1024, 204, 0);
		run_line();
		shading_en_i <= 1'b0;
		detect_thr_i <= 12'hC00;
		detect_start_i <= 1'b1;
		@(posedge clk_i);
		detect_start_i <= 1'b0;
		@(negedge clk_i);
		check("detect_busy", detect_busy_o, 1);
		fill(400, 800, 0, 0);
		run_line();
		defect_line(0);
		for (int w = 0; w < 200 && detect_busy_o !== 1'b0; w++) @(posedge clk_i);
		check("detect_done", detect_busy_o, 0);
		defect_en_i <= 1'b1;
		defect_line(1);
		defect_en_i <= 1'b0;
		defect_line(0);
		check("queue_left", 16'(sb_q.size()), 0);
		timing(3000, 2490);
		exp_mode_i <= EXP_TIMED;
		shut_b_i <= 14'd160;
		timing(3000, 2400);
		{shut_a_i, shut_b_i} <= {14'd380, 14'd380};
		timing(3000, 2490);
		// shutter balance is taken in timed mode and stops once the line sums match
		shutter_balance_cmd_i <= 1'b1;
		@(posedge clk_i);
		shutter_balance_cmd_i <= 1'b0;
		@(negedge clk_i);
		check("shut_bal_go", balance_busy_o, 1);
		fill(700, 700, 0, 0);
		run_line();
		check("shut_bal_done", balance_busy_o, 0);
		exp_mode_i <= EXP_OFF;
		shutter_balance_cmd_i <= 1'b1;
		@(posedge clk_i);
		shutter_balance_cmd_i <= 1'b0;
		repeat (3) @(negedge clk_i);
		check("shut_bal_refused", balance_busy_o, 0);
		// gain balance steps channel two down one code after a line where it reads brighter
		@(posedge clk_i);
		gain_balance_cmd_i <= 1'b1;
		@(posedge clk_i);
		gain_balance_cmd_i <= 1'b0;
		fill(800, 900, 0, 0);
		run_line();
		check("bal_step", fine_gain_b_o, 10'd307);
		fill(700, 700, 0, 0);
		run_line();
		check("bal_done", {balance_busy_o, fine_gain_b_o}, {1'b0, 10'd307});
		auto_rate_i <= 1'b1;
		timing(LMAX * 15, (LMAX - 34) * 15);
		auto_rate_i <= 1'b0;
		trig_mode_i <= 1'b1;
		exp_mode_i <= EXP_TIMED;
		fe.trig_gap = 3000;
		timing(3000, -2490);
		stop_test();
	end
endmodule : tb
